// File: test/drcd_src_model.sv
// Board clock source and control logic that drive the divider pins
`timescale 1ns/100ps
`default_nettype none
module drcd_src_model (
  // Clock and control pins
  output logic o_ref_clk,
  output logic o_sys_rst,
  output logic o_clk_en,
  output logic o_master_clear,
  output logic o_hold_gate,
  output logic o_pick_first,
  output logic o_pick_second
);
  initial begin
    o_ref_clk = 1'h0;
    o_sys_rst = 1'h1;
    o_clk_en = 1'h1;
    o_master_clear = 1'h0;
    o_hold_gate = 1'h0;
    o_pick_first = 1'h0;
    o_pick_second = 1'h0;
  end
  always #5 o_ref_clk = ~o_ref_clk;
  ////////////////////////////////////////////////////////////////
  // Called at a falling edge; non-blocking so the gate flop sees the old level
  task automatic put(input logic rst, input logic en, input logic mc, input logic g,
                     input logic pf, input logic ps);
    o_sys_rst <= rst;
    o_clk_en <= en;
    o_master_clear <= mc;
    o_hold_gate <= g;
    o_pick_first <= pf;
    o_pick_second <= ps;
  endtask
endmodule
`default_nettype wire

// File: test/testbench.sv
// Self-checking bench for the dual ratio clock divider
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import drcd_pkg::*;
  logic clk, rst, en, mc, gate, pf, ps;
  logic [1:0] ft, fc, st, sc;
  int fail_count = 0;
  int compares = 0;
  drcd_src_model src (.o_ref_clk(clk), .o_sys_rst(rst), .o_clk_en(en),
    .o_master_clear(mc), .o_hold_gate(gate), .o_pick_first(pf), .o_pick_second(ps));
  drcd_divider dut (.i_ref_clk(clk), .i_clk_en(en), .i_sys_rst(rst),
    .i_master_clear(mc), .i_hold_gate(gate), .i_ratio_pick_first(pf),
    .i_ratio_pick_second(ps), .o_first_true(ft), .o_first_comp(fc),
    .o_second_true(st), .o_second_comp(sc));
  ////////////////////////////////////////////////////////////////
  task automatic give_verdict;
    if (fail_count == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // Both groups compared in one sample, so a skew between them shows
  task automatic expect_out(input logic [1:0] t1, input logic [1:0] t2);
    compares++;
    if ({ft, fc, st, sc} !== {t1, ~t1, t2, ~t2}) begin
      fail_count++;
      $display("MISMATCH %0t outputs %b %b %b %b", $time, ft, fc, st, sc);
    end
  endtask
  // Clear, then divide with a hold window and a clock enable gap
  task automatic walk(input logic p1, input logic p2);
    int n, h1, h2;
    logic held, en_now, gt, ena;
    n = 0;
    held = 1'h0;
    en_now = 1'h1;
    h1 = p1 ? 2 : 1;
    h2 = p2 ? 3 : 2;
    @(negedge clk);
    src.put(1'h0, 1'h1, 1'h1, 1'h0, p1, p2);
    #1 expect_out(2'h0, 2'h0);
    @(negedge clk);
    src.put(1'h0, 1'h1, 1'h0, 1'h0, p1, p2);
    for (int k = 0; k < 30; k++) begin
      @(negedge clk);
      if (!held && en_now) n++;
      expect_out({2{(n / h1) % 2 == 1}}, {2{(n / h2) % 2 == 1}});
      // Gate level seen by the falling edge flop rules the next rising edge
      if (en_now) held = gate;
      gt = (k >= 8 && k < 12);
      ena = !(k >= 18 && k < 20);
      en_now = ena;
      src.put(1'h0, ena, 1'h0, gt, p1, p2);
    end
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    repeat (10) @(negedge clk);
    expect_out(2'h0, 2'h0);
    src.put(1'h0, 1'h1, 1'h0, 1'h0, 1'h0, 1'h0);
    walk(1'h0, 1'h0);
    walk(1'h1, 1'h0);
    walk(1'h0, 1'h1);
    walk(1'h1, 1'h1);
    give_verdict();
  end
  // About 140 cycles are needed; the limit leaves a wide margin
  initial begin
    #5000;
    fail_count++;
    give_verdict();
  end
endmodule
`default_nettype wire

// File: verilog/drcd_divider.sv
// Dual ratio clock divider: divide by 2 or 4 and divide by 4 or 6 groups
// Summary of operation
// - Both dividers step on the same input clock edge, so shared edges align.
// - Gate changes take effect only while the input clock is low.
// - Gate input is captured on the falling edge of the input clock.
// - Both groups stay in step within one device without master clear.
// - With clear low, gate low and clock enable high, dividers advance on every rising edge.
// - With clear low and gate sampled high, all outputs hold.
// - Master clear high resets all outputs at once, ignoring clock and gate.
// - First select low divides by 2, high divides by 4.
// - Second select low divides by 4, high divides by 6.
// - Control inputs have no default level; driven low they give divide, not cleared, lower ratios.
// - Each group has two outputs with a true and a complement line.
`timescale 1ns/100ps
`default_nettype none
module drcd_divider
  import drcd_pkg::*;
(
  // Clock, enable and reset
  input wire logic i_ref_clk,
  input wire logic i_clk_en,
  input wire logic i_sys_rst,
  // Control pins
  input wire logic i_master_clear,
  input wire logic i_hold_gate,
  input wire logic i_ratio_pick_first,
  input wire logic i_ratio_pick_second,
  // First group outputs
  output logic [1:0] o_first_true,
  output logic [1:0] o_first_comp,
  // Second group outputs
  output logic [1:0] o_second_true,
  output logic [1:0] o_second_comp
);

  ////////////////////////////////////////////////////////////////////////////
  // Gate capture
  logic gate_reg;
  wire logic adv_w;

  // Falling edge capture means the gated clock only changes while low
  always_ff @(negedge i_ref_clk) begin
    if (i_sys_rst) begin
      gate_reg <= GATE_RESET;
    end else if (i_clk_en) begin
      gate_reg <= i_hold_gate;
    end
  end

  assign adv_w = i_clk_en && !gate_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Half period counters, both stepped by the one advance term
  drcd_step_if first_if ();
  drcd_step_if second_if ();

  assign first_if.step = adv_w;
  assign first_if.srst = i_sys_rst;
  assign first_if.clear = i_master_clear;
  assign first_if.ratio_hi = i_ratio_pick_first;
  assign second_if.step = adv_w;
  assign second_if.srst = i_sys_rst;
  assign second_if.clear = i_master_clear;
  assign second_if.ratio_hi = i_ratio_pick_second;

  drcd_half_counter #(
    .LO_LAST(FIRST_LO_LAST),
    .HI_LAST(FIRST_HI_LAST)
  ) u_first_cnt (
    .i_ref_clk(i_ref_clk),
    .i_clk_en(i_clk_en),
    .ifc(first_if.cnt)
  );

  drcd_half_counter #(
    .LO_LAST(SECOND_LO_LAST),
    .HI_LAST(SECOND_HI_LAST)
  ) u_second_cnt (
    .i_ref_clk(i_ref_clk),
    .i_clk_en(i_clk_en),
    .ifc(second_if.cnt)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Output stage: true and complement each from its own flop
  logic [NUM_OUT-1:0] true_reg;
  logic [NUM_OUT-1:0] comp_reg;
  wire logic [NUM_OUT-1:0] tog_w;

  assign tog_w = {second_if.toggle, second_if.toggle, first_if.toggle, first_if.toggle};

  for (genvar g = 0; g < NUM_OUT; g++) begin : g_out
    always_ff @(posedge i_ref_clk or posedge i_master_clear) begin
      if (i_master_clear) begin
        true_reg[g] <= TRUE_RESET;
        comp_reg[g] <= COMP_RESET;
      end else if (i_sys_rst) begin
        true_reg[g] <= TRUE_RESET;
        comp_reg[g] <= COMP_RESET;
      end else if (i_clk_en && tog_w[g]) begin
        true_reg[g] <= !true_reg[g];
        comp_reg[g] <= !comp_reg[g];
      end
    end
  end

  assign o_first_true = true_reg[1:0];
  assign o_first_comp = comp_reg[1:0];
  assign o_second_true = true_reg[3:2];
  assign o_second_comp = comp_reg[3:2];

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_sys_rst || i_master_clear);

  a_comp_inverse: assert property (comp_reg == ~true_reg)
    else $error("complement line does not mirror true line");

  a_group_pairs: assert property (
    o_first_true[0] == o_first_true[1] && o_second_true[0] == o_second_true[1])
    else $error("outputs of one group disagree");

  a_gate_capture: assert property (@(negedge i_ref_clk) disable iff (i_sys_rst)
    i_clk_en |=> gate_reg == $past(i_hold_gate))
    else $error("gate not captured on falling edge");

  a_hold_outputs: assert property (gate_reg && i_clk_en |=> $stable(true_reg))
    else $error("outputs moved while gate held");

  a_first_div2: assert property (
    adv_w && !i_ratio_pick_first |=> o_first_true[0] != $past(o_first_true[0]))
    else $error("first group did not divide by 2");

  a_first_div4: assert property (
    (adv_w && i_ratio_pick_first && first_if.toggle) ##1 (adv_w && i_ratio_pick_first)[*2]
    |-> first_if.toggle && !$past(first_if.toggle))
    else $error("first group did not divide by 4");

  a_second_div4: assert property (
    (adv_w && !i_ratio_pick_second && second_if.toggle) ##1
    (adv_w && !i_ratio_pick_second)[*2] |-> second_if.toggle && !$past(second_if.toggle))
    else $error("second group did not divide by 4");

  a_second_div6: assert property (
    (adv_w && i_ratio_pick_second && second_if.toggle) ##1
    (adv_w && i_ratio_pick_second)[*3]
    |-> second_if.toggle && !$past(second_if.toggle) && !$past(second_if.toggle, 2))
    else $error("second group did not divide by 6 evenly");

  a_edges_aligned: assert property (
    (i_ratio_pick_first && !i_ratio_pick_second && adv_w && second_if.toggle)
    |-> first_if.toggle || (o_first_true[0] != o_second_true[0]))
    else $error("common edges of the two groups not aligned");

  a_clear_low: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    i_master_clear ##1 i_master_clear |-> true_reg == '0 && comp_reg == '1)
    else $error("outputs not cleared by master clear");

  c_div6_run: cover property (
    (adv_w && i_ratio_pick_second)[*6] ##1 second_if.toggle);
  c_hold_run: cover property (gate_reg && i_clk_en ##1 gate_reg && i_clk_en ##1 !gate_reg);
  c_div4_first: cover property ((adv_w && i_ratio_pick_first)[*4]);
  c_clear_seen: cover property (@(posedge i_ref_clk) i_master_clear ##1 !i_master_clear);

endmodule
`default_nettype wire

// File: verilog/drcd_half_counter.sv
// Half period counter for one divider group
`timescale 1ns/100ps
`default_nettype none
module drcd_half_counter
  import drcd_pkg::*;
#(
  parameter logic [1:0] LO_LAST = 2'h0,
  parameter logic [1:0] HI_LAST = 2'h1
) (
  // Clock and enable
  input wire logic i_ref_clk,
  input wire logic i_clk_en,
  // Control and toggle request
  drcd_step_if.cnt ifc
);
  logic [CNT_W-1:0] cnt_reg;
  logic [CNT_W-1:0] cnt_next;
  wire logic [CNT_W-1:0] last_w;

  assign last_w = ifc.ratio_hi ? HI_LAST : LO_LAST;
  // Compare with >= so a ratio change mid period cannot strand the count
  assign ifc.toggle = ifc.step && (cnt_reg >= last_w);
  assign cnt_next = ifc.toggle ? CNT_RESET : cnt_reg + CNT_ONE;

  always_ff @(posedge i_ref_clk or posedge ifc.clear) begin
    if (ifc.clear) begin
      cnt_reg <= CNT_RESET;
    end else if (ifc.srst) begin
      cnt_reg <= CNT_RESET;
    end else if (i_clk_en && ifc.step) begin
      cnt_reg <= cnt_next;
    end
  end
endmodule
`default_nettype wire

// File: verilog/drcd_pkg.sv
// Constants shared by the dual ratio clock divider modules
package drcd_pkg;
  localparam int CNT_W = 2;
  localparam int NUM_OUT = 4;
  // Last count of a half period, as half period minus one
  localparam logic [1:0] FIRST_LO_LAST = 2'h0;
  localparam logic [1:0] FIRST_HI_LAST = 2'h1;
  localparam logic [1:0] SECOND_LO_LAST = 2'h1;
  localparam logic [1:0] SECOND_HI_LAST = 2'h2;
  localparam logic [1:0] CNT_RESET = 2'h0;
  localparam logic [1:0] CNT_ONE = 2'h1;
  localparam logic GATE_RESET = 1'h0;
  localparam logic TRUE_RESET = 1'h0;
  localparam logic COMP_RESET = 1'h1;
endpackage

// File: verilog/drcd_step_if.sv
// Link between the output stage and one half period counter
`timescale 1ns/100ps
`default_nettype none
interface drcd_step_if;
  logic step;
  logic srst;
  logic clear;
  logic ratio_hi;
  logic toggle;
  modport ctl (output step, output srst, output clear, output ratio_hi, input toggle);
  modport cnt (input step, input srst, input clear, input ratio_hi, output toggle);
endinterface
`default_nettype wire
